/* cct_timer.sv */
`timescale 1ns/1ps
module cct_timer
	import cct_pkg::*;
(
	input  wire logic        pclk,          // Peripheral clock, 40 MHz
	input  wire logic        presetn,       // Async reset, low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [7:0]  paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire logic        capture_input_pin,   // Capture / clock pin
	input  wire logic        internal_pulse_input,// Internal pulse source
	input  wire logic        trigger_pin,   // External start trigger
	input  wire logic        idle_mode,     // Low-power idle request
	output logic             timer_flipflop,// Timer flip-flop out
	output logic             irq            // Masked interrupt request
);
	import cct_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic        chan_en_ff, run_ff, prun_ff, started_ff, ff_ff;
	cct_cfg_t    cfg_ff;
	cct_evt_t    flag_ff, mask_ff;
	logic [15:0] uc_ff, snap_ff, cmp0_ff, cmp1_ff, buf0_ff, buf1_ff;
	logic [15:0] cap0_ff, cap1_ff;
	logic        wr0_ff, wr1_ff;
	logic [3:0]  pre_ff;
	logic [2:0]  pin_s, pin_d_ff;
	logic [31:0] rdata_ff;
	logic        irq_ff, pready_ff, pslverr_ff;

	cct_sync #(.W(3)) u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d_in    ({trigger_pin, internal_pulse_input, capture_input_pin}),
		.q_out   (pin_s)
	);

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire setup   = psel & ~penable;
	wire acc     = psel & penable & pready_ff;
	wire wr      = acc & pwrite;
	wire rd      = acc & ~pwrite;
	wire a_en    = (paddr == CCT_OFS_ENABLE);
	wire a_run   = (paddr == CCT_OFS_RUN);
	wire a_ctl   = (paddr == CCT_OFS_CONTROL);
	wire a_mod   = (paddr == CCT_OFS_MODE);
	wire a_ffc   = (paddr == CCT_OFS_FFCTRL);
	wire a_st    = (paddr == CCT_OFS_STATUS);
	wire a_msk   = (paddr == CCT_OFS_MASK);
	wire a_snp   = (paddr == CCT_OFS_SNAPSHOT);
	wire a_c0    = (paddr == CCT_OFS_CMP0);
	wire a_c1    = (paddr == CCT_OFS_CMP1);
	wire a_p0    = (paddr == CCT_OFS_CAP0);
	wire a_p1    = (paddr == CCT_OFS_CAP1);
	wire mapped  = a_en | a_run | a_ctl | a_mod | a_ffc | a_st | a_msk | a_snp
		| a_c0 | a_c1 | a_p0 | a_p1;
	// Other registers are unreachable while the channel is off
	wire gated   = ~a_en & ~chan_en_ff;
	wire bad     = ~mapped | gated;
	wire wr_ok   = wr & ~bad;
	wire rd_ok   = rd & ~bad;

	// ****************************************************************
	// Source clock: prescaler taps and pin edges
	// ****************************************************************
	wire [3:0] pre_nxt = pre_ff + 4'h1;
	wire [3:0] rise_b  = pre_nxt & ~pre_ff;
	// Taps /32../256 extend the 4-bit chain with a small divider
	logic [3:0] ext_ff;
	wire        pre_wrap = prun_ff & (pre_ff == CCT_PRE_MAX);
	wire [7:0]  tick_v;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_tap
			if (gi == 0)
				assign tick_v[gi] = 1'b0;
			else if (gi == 1)
				assign tick_v[gi] = prun_ff;
			else if (gi <= 3)
				assign tick_v[gi] = prun_ff & (&pre_ff[2*gi-3:0]);
			else
				assign tick_v[gi] = pre_wrap & (&ext_ff[gi-4:0]);
		end
	endgenerate
	wire pin_rise  = pin_s[0] & ~pin_d_ff[0];
	wire pin_fall  = ~pin_s[0] & pin_d_ff[0];
	wire pls_rise  = pin_s[1] & ~pin_d_ff[1];
	wire pls_fall  = ~pin_s[1] & pin_d_ff[1];
	wire trg_edge  = cfg_ff.trig_fall ? (~pin_s[2] & pin_d_ff[2])
		: (pin_s[2] & ~pin_d_ff[2]);
	wire src_tick  = (cfg_ff.clk_sel == 3'h0) ? pin_rise : tick_v[cfg_ff.clk_sel];
	wire halted    = idle_mode & ~cfg_ff.idle_run;
	wire counting  = chan_en_ff & run_ff & started_ff & ~halted;
	wire step      = counting & src_tick;

	// ****************************************************************
	// Match, overflow and capture events
	// ****************************************************************
	wire m0      = counting & (uc_ff == cmp0_ff);
	wire m1      = counting & (uc_ff == cmp1_ff);
	wire clr_uc  = step & cfg_ff.clr_match & m1;
	wire ovf     = step & (uc_ff == 16'hffff) & ~clr_uc;
	wire soft_cp = wr_ok & a_mod & ~pwdata[CCT_SCAP_BIT];
	wire pin_md  = (cfg_ff.cap_sel == CCT_CAP_RISE) | (cfg_ff.cap_sel == CCT_CAP_PIN);
	wire cap0_ev = soft_cp | (chan_en_ff & ((pin_md & pin_rise)
		| ((cfg_ff.cap_sel == CCT_CAP_PLS) & pls_rise)));
	wire cap1_ev = chan_en_ff & (((cfg_ff.cap_sel == CCT_CAP_PIN) & pin_fall)
		| ((cfg_ff.cap_sel == CCT_CAP_PLS) & pls_fall));
	wire [3:0] tg_src = {cap1_ev, cap0_ev, m1 & step, m0 & step};
	wire tog_hw  = |(tg_src & cfg_ff.toggle_en);

	// Compare buffer transfer point: counter rolling back to zero
	wire reload  = clr_uc | ovf;
	wire xfer    = cfg_ff.dbuf & reload & (~cfg_ff.pair | (wr0_ff & wr1_ff));

	// ****************************************************************
	// Read data mux
	// ****************************************************************
	wire [31:0] rd_mux =
		a_en  ? {24'h0, chan_en_ff, 7'h0} :
		a_run ? {29'h0, prun_ff, 1'b0, run_ff} :
		a_ctl ? {24'h0, cfg_ff.dbuf, 3'h0, cfg_ff.idle_run, 1'b0, cfg_ff.trig_fall,
			cfg_ff.ext_start} :
		a_mod ? {24'h0, cfg_ff.pair, 1'b1, cfg_ff.cap_sel, cfg_ff.clr_match,
			cfg_ff.clk_sel} :
		a_ffc ? {24'h0, CCT_FFCR_HIGH, cfg_ff.toggle_en, CCT_FFCMD_NONE} :
		a_st  ? {29'h0, flag_ff} :
		a_msk ? {29'h0, mask_ff} :
		a_snp ? {16'h0, (run_ff ? uc_ff : snap_ff)} :
		a_c0  ? {16'h0, cmp0_ff} :
		a_c1  ? {16'h0, cmp1_ff} :
		a_p0  ? {16'h0, cap0_ff} :
		{16'h0, cap1_ff};

	// ****************************************************************
	// Bus handshake: no wait states, reads registered
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			rdata_ff   <= 32'h0;
		end
		else
		begin
			pready_ff  <= setup;
			pslverr_ff <= setup & bad;
			rdata_ff   <= (setup & ~bad & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// ****************************************************************
	// Control and configuration registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chan_en_ff <= 1'b0;
			run_ff     <= 1'b0;
			prun_ff    <= 1'b0;
			cfg_ff     <= '0;
			mask_ff    <= '0;
		end
		else if (wr_ok)
		begin
			if (a_en)
				chan_en_ff <= pwdata[CCT_EN_BIT];
			if (a_run)
			begin
				run_ff  <= pwdata[CCT_RUN_BIT];
				prun_ff <= pwdata[CCT_PRUN_BIT];
			end
			if (a_ctl)
			begin
				cfg_ff.dbuf      <= pwdata[CCT_DBUF_BIT];
				cfg_ff.idle_run  <= pwdata[CCT_IDLE_BIT];
				cfg_ff.trig_fall <= pwdata[CCT_TRGE_BIT];
				cfg_ff.ext_start <= pwdata[CCT_SSEL_BIT];
			end
			if (a_mod)
			begin
				cfg_ff.pair      <= pwdata[CCT_PAIR_BIT];
				cfg_ff.cap_sel   <= pwdata[5:4];
				cfg_ff.clr_match <= pwdata[CCT_CLR_BIT];
				cfg_ff.clk_sel   <= pwdata[2:0];
			end
			if (a_ffc)
				cfg_ff.toggle_en <= pwdata[5:2];
			if (a_msk)
				mask_ff <= pwdata[2:0];
		end
	end

	// ****************************************************************
	// Prescaler, start control and up-counter
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_ff     <= 4'h0;
			ext_ff     <= 4'h0;
			started_ff <= 1'b0;
			uc_ff      <= 16'h0;
			snap_ff    <= 16'h0;
			pin_d_ff   <= 3'h0;
		end
		else
		begin
			pin_d_ff <= pin_s;
			// Prescaler freezes with the channel clock gated off
			if (!prun_ff)
			begin
				pre_ff <= 4'h0;
				ext_ff <= 4'h0;
			end
			else if (chan_en_ff & ~halted)
			begin
				pre_ff <= pre_nxt;
				if (pre_wrap)
					ext_ff <= ext_ff + 4'h1;
			end
			// Trigger start waits for the chosen edge once armed
			if (!run_ff)
				started_ff <= 1'b0;
			else if (!cfg_ff.ext_start | trg_edge)
				started_ff <= 1'b1;
			if (!run_ff)
				uc_ff <= 16'h0;
			else if (clr_uc)
				uc_ff <= 16'h0;
			else if (step)
				uc_ff <= uc_ff + 16'h1;
			if (rd_ok & a_snp & run_ff)
				snap_ff <= uc_ff;
		end
	end

	// ****************************************************************
	// Compare registers with double buffers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp0_ff <= 16'h0;
			cmp1_ff <= 16'h0;
			buf0_ff <= 16'h0;
			buf1_ff <= 16'h0;
			wr0_ff  <= 1'b0;
			wr1_ff  <= 1'b0;
		end
		else
		begin
			if (wr_ok & a_c0)
				buf0_ff <= pwdata[15:0];
			if (wr_ok & a_c1)
				buf1_ff <= pwdata[15:0];
			// Without buffering, writes land directly
			if (wr_ok & a_c0 & ~cfg_ff.dbuf)
				cmp0_ff <= pwdata[15:0];
			else if (xfer)
				cmp0_ff <= buf0_ff;
			if (wr_ok & a_c1 & ~cfg_ff.dbuf)
				cmp1_ff <= pwdata[15:0];
			else if (xfer)
				cmp1_ff <= buf1_ff;
			// Markers pend only while buffering; a new write beats the clear
			wr0_ff <= cfg_ff.dbuf & ((wr_ok & a_c0) | (wr0_ff & ~xfer));
			wr1_ff <= cfg_ff.dbuf & ((wr_ok & a_c1) | (wr1_ff & ~xfer));
		end
	end

	// ****************************************************************
	// Capture registers, flip-flop, flags and interrupt
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap0_ff <= 16'h0;
			cap1_ff <= 16'h0;
			ff_ff   <= 1'b0;
			flag_ff <= '0;
			irq_ff  <= 1'b0;
		end
		else
		begin
			if (cap0_ev)
				cap0_ff <= uc_ff;
			if (cap1_ev)
				cap1_ff <= uc_ff;
			if (wr_ok & a_ffc & (pwdata[1:0] == CCT_FF_SET))
				ff_ff <= 1'b1;
			else if (wr_ok & a_ffc & (pwdata[1:0] == CCT_FF_CLR))
				ff_ff <= 1'b0;
			else if (wr_ok & a_ffc & (pwdata[1:0] == CCT_FF_INV))
				ff_ff <= ~ff_ff ^ tog_hw;
			else if (tog_hw)
				ff_ff <= ~ff_ff;
			// Clear only what the read returned; a new set wins
			flag_ff <= (flag_ff & ~(rdata_ff[2:0] & {3{rd_ok & a_st}}))
				| {ovf, m1 & step, m0 & step};
			irq_ff  <= |({ovf, m1 & step, m0 & step} & mask_ff);
		end
	end

	assign prdata         = rdata_ff;
	assign pready         = pready_ff;
	assign pslverr        = pslverr_ff;
	assign timer_flipflop = ff_ff;
	assign irq            = irq_ff;
endmodule

/* cct_pkg.sv */
package cct_pkg;
	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] CCT_OFS_ENABLE   = 8'h00;
	localparam logic [7:0] CCT_OFS_RUN      = 8'h04;
	localparam logic [7:0] CCT_OFS_CONTROL  = 8'h08;
	localparam logic [7:0] CCT_OFS_MODE     = 8'h0c;
	localparam logic [7:0] CCT_OFS_FFCTRL   = 8'h10;
	localparam logic [7:0] CCT_OFS_STATUS   = 8'h14;
	localparam logic [7:0] CCT_OFS_MASK     = 8'h18;
	localparam logic [7:0] CCT_OFS_SNAPSHOT = 8'h1c;
	localparam logic [7:0] CCT_OFS_CMP0     = 8'h20;
	localparam logic [7:0] CCT_OFS_CMP1     = 8'h24;
	localparam logic [7:0] CCT_OFS_CAP0     = 8'h28;
	localparam logic [7:0] CCT_OFS_CAP1     = 8'h2c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CCT_EN_BIT      = 7;
	localparam int CCT_RUN_BIT     = 0;
	localparam int CCT_PRUN_BIT    = 2;
	localparam int CCT_DBUF_BIT    = 7;
	localparam int CCT_IDLE_BIT    = 3;
	localparam int CCT_TRGE_BIT    = 1;
	localparam int CCT_SSEL_BIT    = 0;
	localparam int CCT_PAIR_BIT    = 7;
	localparam int CCT_SCAP_BIT    = 6;
	localparam int CCT_CLR_BIT     = 3;

	// ****************************************************************
	// Reset and fixed read values, prescaler limit
	// ****************************************************************
	localparam logic [7:0] CCT_MODE_RST   = 8'h40;
	localparam logic [7:0] CCT_FFCR_RST   = 8'hc3;
	localparam logic [1:0] CCT_FFCMD_NONE = 2'h3;
	localparam logic [1:0] CCT_FFCR_HIGH  = 2'h3;
	localparam logic [3:0] CCT_PRE_MAX    = 4'hf;

	// Capture edge modes
	localparam logic [1:0] CCT_CAP_OFF  = 2'h0;
	localparam logic [1:0] CCT_CAP_RISE = 2'h1;
	localparam logic [1:0] CCT_CAP_PIN  = 2'h2;
	localparam logic [1:0] CCT_CAP_PLS  = 2'h3;

	// Flip-flop commands
	localparam logic [1:0] CCT_FF_INV = 2'h0;
	localparam logic [1:0] CCT_FF_SET = 2'h1;
	localparam logic [1:0] CCT_FF_CLR = 2'h2;

	// Event flag bundle
	typedef struct packed
	{
		logic ovf;
		logic m1;
		logic m0;
	} cct_evt_t;

	// Configuration bundle
	typedef struct packed
	{
		logic       dbuf;
		logic       idle_run;
		logic       trig_fall;
		logic       ext_start;
		logic       pair;
		logic [1:0] cap_sel;
		logic       clr_match;
		logic [2:0] clk_sel;
		logic [3:0] toggle_en;
	} cct_cfg_t;
endpackage

/* cct_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two-stage synchroniser for pin level inputs
// ****************************************************************
module cct_sync
#(
	parameter int W = 3
)
(
	input  wire logic         pclk,     // Peripheral clock
	input  wire logic         presetn,  // Async reset, low
	input  wire logic [W-1:0] d_in,     // Asynchronous levels
	output logic      [W-1:0] q_out     // Synchronised levels
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// First stage read only by the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= '0;
			q_ff    <= '0;
		end
		else
		begin
			meta_ff <= d_in;
			q_ff    <= meta_ff;
		end
	end

	assign q_out = q_ff;
endmodule

/* cct_pin_model.sv */
`timescale 1ns/1ps
// ********************
// Pin-side partner
// ********************
module cct_pin_model
(
	input  wire logic pclk,    // Peripheral clock
	output logic      cap_pin, // Capture or clock pin
	output logic      pls_pin, // Internal pulse level
	output logic      trg_pin  // Start trigger pin
);
	// All lines rest low between pulses
	initial
	begin
		cap_pin = 1'b0;
		pls_pin = 1'b0;
		trg_pin = 1'b0;
	end

	// Source 0 capture, 1 pulse, 2 trigger; high for hi, then low for hi
	task automatic pulse(input int src, input int hi);
		@(posedge pclk);
		if (src == 2)
			trg_pin <= 1'b1;
		else if (src == 1)
			pls_pin <= 1'b1;
		else
			cap_pin <= 1'b1;
		repeat (hi) @(posedge pclk);
		if (src == 2)
			trg_pin <= 1'b0;
		else if (src == 1)
			pls_pin <= 1'b0;
		else
			cap_pin <= 1'b0;
		repeat (hi) @(posedge pclk);
	endtask
endmodule

/* cct_timer_chk.sv */
`timescale 1ns/1ps
// ********************
// Port checker
// ********************
module cct_timer_chk
	import cct_pkg::*;
(
	input wire logic        pclk,           // Clock
	input wire logic        presetn,        // Reset, low
	input wire logic        psel,           // APB select
	input wire logic        penable,        // APB enable
	input wire logic        pwrite,         // APB direction
	input wire logic [7:0]  paddr,          // APB address
	input wire logic [31:0] pwdata,         // APB write data
	input wire logic [31:0] prdata,         // APB read data
	input wire logic        pready,         // APB ready
	input wire logic        pslverr,        // APB error
	input wire logic        timer_flipflop, // Flip-flop out
	input wire logic        irq             // Interrupt pulse
);
	logic       en_ff;
	logic [2:0] mask_ff;
	logic [3:0] tog_ff;
	// Completed transfers; ffw only while toggles are off, so no event races
	wire logic acc = psel && penable && pready;
	wire logic wr  = acc && pwrite && !pslverr;
	wire logic rd  = acc && !pwrite && !pslverr;
	wire logic ffw = wr && paddr == CCT_OFS_FFCTRL && tog_ff == 4'h0;

	// Shadows of enable, mask and toggle enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_ff   <= 1'b0;
			mask_ff <= 3'h0;
			tog_ff  <= 4'h0;
		end
		else if (wr && paddr == CCT_OFS_ENABLE)
			en_ff <= pwdata[CCT_EN_BIT];
		else if (wr && paddr == CCT_OFS_MASK)
			mask_ff <= pwdata[2:0];
		else if (wr && paddr == CCT_OFS_FFCTRL)
			tog_ff <= pwdata[5:2];
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_SETUP_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	AST_OFF_REFUSED: assert property (acc && !en_ff && paddr != CCT_OFS_ENABLE |-> pslverr)
		else $error("access to disabled channel accepted");
	AST_SCAP_ONE: assert property (rd && paddr == CCT_OFS_MODE |-> prdata[CCT_SCAP_BIT])
		else $error("soft capture bit reads zero");
	AST_FFCR_READ: assert property (rd && paddr == CCT_OFS_FFCTRL |-> prdata[1:0] == 2'h3)
		else $error("flip-flop command reads wrong");
	AST_FF_SET: assert property (ffw && pwdata[1:0] == CCT_FF_SET |=> timer_flipflop)
		else $error("flip-flop not set");
	AST_FF_CLR: assert property (ffw && pwdata[1:0] == CCT_FF_CLR |=> !timer_flipflop)
		else $error("flip-flop not cleared");
	AST_FF_INV: assert property (ffw && pwdata[1:0] == CCT_FF_INV |=> $changed(timer_flipflop))
		else $error("flip-flop not inverted");
	AST_IRQ_MASKED: assert property (irq |-> (mask_ff | $past(mask_ff)) != 3'h0)
		else $error("irq with all sources masked");
endmodule

bind cct_timer cct_timer_chk chk_u
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.timer_flipflop(timer_flipflop),
	.irq(irq)
);

/* cct_timer_tb.sv */
`timescale 1ns/1ps
// ********************
// Timer channel bench
// ********************
module cct_timer_tb;
	import cct_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_pin;
	logic        pls_pin;
	logic        trg_pin;
	logic        idle_mode;
	logic        tff;
	logic        irq;
	logic [31:0] rd_q;
	logic        err_q;
	int          mismatches;
	int          compares;
	int          cyc;
	int          irqs;

	cct_timer dut_u
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.capture_input_pin(cap_pin),
		.internal_pulse_input(pls_pin),
		.trigger_pin(trg_pin),
		.idle_mode(idle_mode),
		.timer_flipflop(tff),
		.irq(irq)
	);

	cct_pin_model pin_u
	(
		.pclk(pclk),
		.cap_pin(cap_pin),
		.pls_pin(pls_pin),
		.trg_pin(trg_pin)
	);

	// Clock, 25 ns period
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Irq tally and hang guard
	always @(posedge pclk)
	begin
		cyc = cyc + 1;
		irqs = irqs + int'(irq === 1'b1);
		if (cyc == 90000)
		begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic near(input logic [31:0] got, input int lo, input int hi);
		chk({31'h0, got >= lo && got <= hi}, 32'h1);
	endtask

	// One APB transfer; pready read as sampled at the edge, then one idle cycle
	task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Stop, reconfigure, start counter and prescaler (0x5)
	task automatic go(input logic [7:0] m);
		xfer(1, CCT_OFS_RUN, 32'h0);
		xfer(1, CCT_OFS_MODE, {24'h0, m});
		xfer(1, CCT_OFS_RUN, 32'h5);
	endtask

	task automatic t_access();
		logic [7:0]  ofs [6];
		logic [31:0] want [6];
		ofs = '{CCT_OFS_CONTROL, CCT_OFS_MODE, CCT_OFS_FFCTRL,
			CCT_OFS_STATUS, CCT_OFS_MASK, CCT_OFS_CAP0};
		want = '{32'h0, 32'h40, 32'hc3, 32'h0, 32'h0, 32'h0};
		xfer(0, CCT_OFS_MODE, 0);
		chk({rd_q[31:1], err_q}, 32'h1);
		xfer(1, CCT_OFS_ENABLE, 32'h80);
		xfer(1, CCT_OFS_CAP0, 32'h1234);
		foreach (ofs[i])
		begin
			xfer(0, ofs[i], 0);
			chk(rd_q, want[i]);
		end
		xfer(0, 8'h30, 0);
		chk({31'h0, err_q}, 32'h1);
	endtask

	task automatic t_ffcmd();
		logic [1:0] cmd [4];
		logic       want [4];
		cmd = '{CCT_FF_SET, CCT_FF_CLR, CCT_FF_INV, CCT_FFCMD_NONE};
		want = '{1'b1, 1'b0, 1'b1, 1'b1};
		foreach (cmd[i])
		begin
			xfer(1, CCT_OFS_FFCTRL, {30'h0, cmd[i]});
			chk({31'h0, tff}, {31'h0, want[i]});
		end
	endtask

	task automatic t_prescale();
		int div [7];
		div = '{1, 4, 16, 32, 64, 128, 256};
		foreach (div[i])
		begin
			go(8'h40 | 8'(i + 1));
			repeat (512) @(posedge pclk);
			xfer(0, CCT_OFS_SNAPSHOT, 0);
			near(rd_q, 512 / div[i] - 1, 520 / div[i] + 1);
		end
		go(8'h40);
		repeat (10) pin_u.pulse(1'b0, 4);
		xfer(0, CCT_OFS_SNAPSHOT, 0);
		chk(rd_q, 32'd10);
		xfer(1, CCT_OFS_RUN, 32'h0);
		xfer(0, CCT_OFS_SNAPSHOT, 0);
		chk(rd_q, 32'd10);
	endtask

	task automatic t_capture();
		logic [15:0] c0;
		xfer(1, CCT_OFS_FFCTRL, {30'h0, CCT_FF_CLR});
		xfer(1, CCT_OFS_FFCTRL, 32'h13);
		for (int s = 0; s < 2; s++)
		begin
			go(8'h61 + 8'(s << 4));
			pin_u.pulse(s[0], 20);
			xfer(0, CCT_OFS_CAP0, 0);
			c0 = rd_q[15:0];
			xfer(0, CCT_OFS_CAP1, 0);
			chk(rd_q - c0, 32'd20);
			chk({31'h0, tff}, {31'h0, s == 0});
		end
		xfer(0, CCT_OFS_SNAPSHOT, 0);
		c0 = rd_q[15:0];
		xfer(1, CCT_OFS_MODE, 32'h31);
		xfer(0, CCT_OFS_CAP0, 0);
		near(rd_q - c0, 2, 5);
	endtask

	task automatic t_match();
		xfer(1, CCT_OFS_RUN, 32'h0);
		xfer(1, CCT_OFS_MASK, 32'h2);
		xfer(1, CCT_OFS_CMP0, 32'd5);
		xfer(1, CCT_OFS_CMP1, 32'd9);
		xfer(0, CCT_OFS_STATUS, 0);
		irqs = 0;
		go(8'h49);
		repeat (100) @(posedge pclk);
		xfer(0, CCT_OFS_SNAPSHOT, 0);
		near(rd_q, 0, 9);
		xfer(1, CCT_OFS_RUN, 32'h0);
		near(irqs, 9, 13);
		xfer(0, CCT_OFS_STATUS, 0);
		chk(rd_q, 32'h3);
		xfer(0, CCT_OFS_STATUS, 0);
		chk(rd_q, 32'h0);
		xfer(0, CCT_OFS_CMP1, 0);
		chk(rd_q, 32'd9);
	endtask

	// Buffered compares: paired transfer, then single transfer
	task automatic t_dbuf();
		xfer(1, CCT_OFS_RUN, 32'h0);
		xfer(1, CCT_OFS_CONTROL, 32'h80);
		go(8'hc9);
		xfer(1, CCT_OFS_CMP0, 32'd3);
		repeat (20) @(posedge pclk);
		xfer(0, CCT_OFS_CMP0, 0);
		chk(rd_q, 32'd5);
		xfer(1, CCT_OFS_CMP1, 32'd7);
		repeat (20) @(posedge pclk);
		xfer(0, CCT_OFS_CMP0, 0);
		chk(rd_q, 32'd3);
		xfer(0, CCT_OFS_CMP1, 0);
		chk(rd_q, 32'd7);
		go(8'h49);
		xfer(1, CCT_OFS_CMP0, 32'd4);
		repeat (20) @(posedge pclk);
		xfer(0, CCT_OFS_CMP0, 0);
		chk(rd_q, 32'd4);
	endtask

	// Trigger start on each edge; selects written before the run bits
	task automatic t_trigger();
		for (int e = 0; e < 2; e++)
		begin
			xfer(1, CCT_OFS_RUN, 32'h0);
			xfer(1, CCT_OFS_CONTROL, 32'h1 | 32'(e << CCT_TRGE_BIT));
			go(8'h41);
			repeat (8) @(posedge pclk);
			xfer(0, CCT_OFS_SNAPSHOT, 0);
			chk(rd_q, 32'h0);
			pin_u.pulse(2, 8);
			xfer(0, CCT_OFS_SNAPSHOT, 0);
			near(rd_q, 12 - 8 * e, 14 - 8 * e);
		end
	endtask

	task automatic t_idle();
		logic [15:0] s1;
		for (int b = 0; b < 2; b++)
		begin
			xfer(1, CCT_OFS_RUN, 32'h0);
			xfer(1, CCT_OFS_CONTROL, 32'(b << CCT_IDLE_BIT));
			go(8'h41);
			idle_mode <= 1'b1;
			repeat (4) @(posedge pclk);
			xfer(0, CCT_OFS_SNAPSHOT, 0);
			s1 = rd_q[15:0];
			xfer(0, CCT_OFS_SNAPSHOT, 0);
			chk(rd_q - s1, 32'(b * 3));
			idle_mode <= 1'b0;
		end
	endtask

	// Restart from zero so exactly one wrap falls inside the window
	task automatic t_overflow();
		xfer(1, CCT_OFS_MASK, 32'h4);
		go(8'h41);
		xfer(0, CCT_OFS_STATUS, 0);
		irqs = 0;
		repeat (65536) @(posedge pclk);
		xfer(0, CCT_OFS_STATUS, 0);
		chk(rd_q & 32'h4, 32'h4);
		chk(32'(irqs), 32'd1);
	endtask

	// Reset, then scenarios in order
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		idle_mode = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_access();
		t_ffcmd();
		t_prescale();
		t_capture();
		t_match();
		t_dbuf();
		t_trigger();
		t_idle();
		t_overflow();
		give_verdict();
	end
endmodule
